// ### pkg/mcfs_pkg.sv
// Constants, field layouts and carrier types of the motor IC frame logic.
// Assumes a 16-bit serial frame, most significant bit first.

package mcfs_pkg;

	// ------------------------------------------------------------
	// Frame geometry
	// ------------------------------------------------------------
	localparam int                 FRAME_BITS   = 16;
	localparam int                 BIT_CNT_W    = 4;
	localparam logic [3:0]         LAST_BIT_IDX = 4'hf;
	localparam logic [15:0]        FRAME_RESET  = 16'h0000;

	// ------------------------------------------------------------
	// Input frame field positions
	// ------------------------------------------------------------
	localparam int                 FRAME_KIND_BIT  = 0;
	localparam int                 INFO_REQ_BIT    = 1;
	localparam int                 SLEEP_BIT       = 2;
	localparam int                 ADC_SPEED_BIT   = 3;
	localparam int                 DRV_C_MODE_BIT  = 4;
	localparam int                 FILTER_BIT      = 5;
	localparam int                 CAL_SEL_LSB     = 6;
	localparam int                 ANALOG_TEST_BIT = 8;
	localparam int                 CAL_DATA_LSB    = 9;
	localparam int                 TEST_FIELD_LSB  = 14;
	localparam int                 CAL_W           = 5;
	localparam int                 CAL_SEL_W       = 2;
	localparam int                 CAL_REGS        = 4;
	localparam logic [CAL_W-1:0]   CAL_RESET       = 5'h00;

	// ------------------------------------------------------------
	// Output frame constants
	// ------------------------------------------------------------
	localparam logic [5:0]         INFO_CODE       = 6'h06;

	// ------------------------------------------------------------
	// Encoder filter depths, in serial clock edges
	// ------------------------------------------------------------
	localparam int                 FILTER_SHORT_EDGES = 2;
	localparam int                 FILTER_LONG_EDGES  = 4;

	typedef enum logic [1:0] {
		CAL_A_GAIN   = 2'h0,
		CAL_A_OFFSET = 2'h1,
		CAL_B_GAIN   = 2'h2,
		CAL_B_OFFSET = 2'h3
	} mcfs_cal_sel_type;

	typedef struct packed {
		logic analog_test;
		logic filter_long;
		logic driver_c_mode_select;
		logic adc_fast;
		logic sleep;
	} mcfs_cfg_type;

	localparam mcfs_cfg_type       CFG_RESET = '0;

	typedef struct packed {
		logic external_reset_cause;
		logic supply_undervoltage;
		logic five_volt_undervoltage;
		logic three_volt_undervoltage;
		logic core_undervoltage;
		logic thermal_shutdown_cause;
		logic thermal_warning;
	} mcfs_status_type;

	localparam mcfs_status_type    STATUS_RESET = '0;

	typedef struct packed {
		logic [7:0] conversion_result;
		logic [2:0] result_channel_tag;
	} mcfs_adc_type;

	localparam mcfs_adc_type       ADC_RESET = '0;

endpackage : mcfs_pkg

// ### design/mcfs_enc_filter.sv
// Digital glitch filter for the two encoder phase signals.
// Assumes raw_in is already synchronised and step_in is a one-cycle strobe.

module mcfs_enc_filter #(
	parameter int W           = 2,
	parameter int SHORT_EDGES = mcfs_pkg::FILTER_SHORT_EDGES,
	parameter int LONG_EDGES  = mcfs_pkg::FILTER_LONG_EDGES
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         en_in,
	input  wire logic         step_in,
	input  wire logic         long_sel_in,
	input  wire logic [W-1:0] raw_in,
	output logic      [W-1:0] filt_out
);
	import mcfs_pkg::*;

	localparam int CW = $clog2(LONG_EDGES + 1);

	if (SHORT_EDGES < 1 || LONG_EDGES < SHORT_EDGES || W < 1) begin : g_bad
		$error("mcfs_enc_filter: depths must satisfy 1 <= SHORT <= LONG");
	end

	localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_EDGES - 1);
	localparam logic [CW-1:0] LONG_LAST  = CW'(LONG_EDGES - 1);

	logic [W-1:0][CW-1:0] cnt_q;
	logic [CW-1:0]        last;

	assign last = long_sel_in ? LONG_LAST : SHORT_LAST;

	// ------------------------------------------------------------
	// A change passes only after standing for the chosen edge count
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= '0;
			filt_out <= '0;
		end else if (en_in) begin
			for (int i = 0; i < W; i++) begin
				if (raw_in[i] == filt_out[i]) begin
					cnt_q[i] <= '0;
				end else if (step_in) begin
					if (cnt_q[i] >= last) begin
						filt_out[i] <= raw_in[i];
						cnt_q[i]    <= '0;
					end else begin
						cnt_q[i] <= cnt_q[i] + CW'(1);
					end
				end
			end
		end
	end

endmodule : mcfs_enc_filter

// ### design/mcfs_frame_core.sv
// Serial frame logic of the motor IC control port: configuration decode
// and assembly of normal and information output frames.
// Assumes a host clocking mode 0 (sample on rising, shift on falling
// serial clock), chip enable active low, serial clock at most clk/10.

module mcfs_frame_core
	import mcfs_pkg::*;
(
	input  wire logic                               clk_in,
	input  wire logic                               rst_in,
	input  wire logic                               en_in,
	input  wire logic                               sclk_in,
	input  wire logic                               ce_n_in,
	input  wire logic                               mosi_in,
	output logic                                    miso_out,
	output logic                                    miso_oe_n_out,
	input  wire mcfs_pkg::mcfs_adc_type             adc_in,
	input  wire logic                               first_done_in,
	input  wire logic                               second_done_in,
	input  wire mcfs_pkg::mcfs_status_type          status_in,
	input  wire logic                               encoder_phase_a_in,
	input  wire logic                               encoder_phase_b_in,
	output mcfs_pkg::mcfs_cfg_type                  cfg_out,
	output logic [mcfs_pkg::CAL_REGS-1:0][mcfs_pkg::CAL_W-1:0] cal_out,
	output logic [mcfs_pkg::FRAME_BITS-1:0]         normal_frame_out,
	output logic                                    normal_valid_out,
	output logic                                    low_side_outputs_en_out,
	output logic                                    high_side_outputs_en_out,
	output logic                                    analog_pin_zero_out,
	output logic                                    analog_pin_one_out
);
	import mcfs_pkg::*;

	// ------------------------------------------------------------
	// Frame builders
	// ------------------------------------------------------------
	function automatic logic [15:0] info_frame(
		input mcfs_status_type st,
		input logic [1:0]      enc
	);
		info_frame = {INFO_CODE,
			st.external_reset_cause,
			st.supply_undervoltage,
			1'b1,
			st.five_volt_undervoltage,
			st.three_volt_undervoltage,
			st.core_undervoltage,
			enc[1],
			enc[0],
			st.thermal_shutdown_cause,
			st.thermal_warning};
	endfunction : info_frame

	function automatic logic [15:0] normal_frame(
		input mcfs_adc_type adc,
		input logic [1:0]   enc,
		input logic         done1,
		input logic         done2
	);
		normal_frame = {adc.conversion_result,
			1'b0,
			adc.result_channel_tag,
			enc[1],
			enc[0],
			done2,
			done1};
	endfunction : normal_frame

	// ------------------------------------------------------------
	// Link domain: receive shifter on the serial clock
	// ------------------------------------------------------------
	logic                 link_rst;
	logic [15:0]          rx_q;
	logic [BIT_CNT_W-1:0] bit_cnt_q;
	logic [15:0]          word_q;
	logic                 word_tgl_q;

	// Chip enable high abandons a partial frame
	assign link_rst = rst_in | ce_n_in;

	always_ff @(posedge sclk_in or posedge link_rst) begin
		if (link_rst) begin
			rx_q      <= FRAME_RESET;
			bit_cnt_q <= '0;
		end else begin
			rx_q      <= {rx_q[14:0], mosi_in};
			bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
		end
	end

	// Word stays put for a whole frame, so the toggle alone may cross
	always_ff @(posedge sclk_in or posedge rst_in) begin
		if (rst_in) begin
			word_q     <= FRAME_RESET;
			word_tgl_q <= 1'b0;
		end else if (bit_cnt_q == LAST_BIT_IDX) begin
			word_q     <= {rx_q[14:0], mosi_in};
			word_tgl_q <= ~word_tgl_q;
		end
	end

	// ------------------------------------------------------------
	// Synchronisers into the system clock
	// ------------------------------------------------------------
	logic            tgl_s1_q;
	logic            tgl_s2_q;
	logic            tgl_s3_q;
	logic            sclk_s1_q;
	logic            sclk_s2_q;
	logic            sclk_s3_q;
	logic            ce_n_s1_q;
	logic            ce_n_s2_q;
	logic            ce_n_s3_q;
	logic [1:0]      enc_s1_q;
	logic [1:0]      enc_s2_q;
	mcfs_status_type st_s1_q;
	mcfs_status_type st_s2_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tgl_s1_q  <= 1'b0;
			tgl_s2_q  <= 1'b0;
			tgl_s3_q  <= 1'b0;
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			ce_n_s1_q <= 1'b1;
			ce_n_s2_q <= 1'b1;
			ce_n_s3_q <= 1'b1;
			enc_s1_q  <= 2'h0;
			enc_s2_q  <= 2'h0;
			st_s1_q   <= STATUS_RESET;
			st_s2_q   <= STATUS_RESET;
		end else if (en_in) begin
			tgl_s1_q  <= word_tgl_q;
			tgl_s2_q  <= tgl_s1_q;
			tgl_s3_q  <= tgl_s2_q;
			sclk_s1_q <= sclk_in;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			ce_n_s1_q <= ce_n_in;
			ce_n_s2_q <= ce_n_s1_q;
			ce_n_s3_q <= ce_n_s2_q;
			enc_s1_q  <= {encoder_phase_b_in, encoder_phase_a_in};
			enc_s2_q  <= enc_s1_q;
			st_s1_q   <= status_in;
			st_s2_q   <= st_s1_q;
		end
	end

	logic frame_done;
	logic sclk_rise;
	logic sclk_fall;
	logic ce_fall;
	logic is_config;
	logic is_normal;

	assign frame_done = tgl_s2_q ^ tgl_s3_q;
	assign sclk_rise  = sclk_s2_q & ~sclk_s3_q;
	assign sclk_fall  = sclk_s3_q & ~sclk_s2_q;
	assign ce_fall    = ce_n_s3_q & ~ce_n_s2_q;
	assign is_config  = frame_done & word_q[FRAME_KIND_BIT];
	assign is_normal  = frame_done & ~word_q[FRAME_KIND_BIT];

	// ------------------------------------------------------------
	// Encoder filter
	// ------------------------------------------------------------
	logic [1:0] enc_filt;

	mcfs_enc_filter #(
		.W           (2),
		.SHORT_EDGES (FILTER_SHORT_EDGES),
		.LONG_EDGES  (FILTER_LONG_EDGES)
	) u_enc_filter (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.en_in       (en_in),
		.step_in     (sclk_rise),
		.long_sel_in (cfg_out.filter_long),
		.raw_in      (enc_s2_q),
		.filt_out    (enc_filt)
	);

	// ------------------------------------------------------------
	// Configuration and calibration
	// ------------------------------------------------------------
	// The test field is not decoded; the host must send it as 10
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_out <= CFG_RESET;
		end else if (en_in && is_config) begin
			cfg_out.analog_test          <= word_q[ANALOG_TEST_BIT];
			cfg_out.filter_long          <= word_q[FILTER_BIT];
			cfg_out.driver_c_mode_select <= word_q[DRV_C_MODE_BIT];
			cfg_out.adc_fast             <= word_q[ADC_SPEED_BIT];
			cfg_out.sleep                <= word_q[SLEEP_BIT];
		end
	end

	mcfs_cal_sel_type cal_sel;

	// Select index: first select bit is the high bit of the code
	assign cal_sel = mcfs_cal_sel_type'(word_q[CAL_SEL_LSB +: CAL_SEL_W]);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cal_out <= {CAL_REGS{CAL_RESET}};
		end else if (en_in && is_config) begin
			cal_out[cal_sel] <= word_q[CAL_DATA_LSB +: CAL_W];
		end
	end

	// ------------------------------------------------------------
	// Normal frames handed on to the motor control logic
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			normal_frame_out <= FRAME_RESET;
			normal_valid_out <= 1'b0;
		end else if (en_in) begin
			normal_valid_out <= is_normal;
			if (is_normal) begin
				normal_frame_out <= word_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Pending flags: set wins over clear
	// ------------------------------------------------------------
	logic         info_pend_q;
	logic         done1_q;
	logic         done2_q;
	logic         load_normal;
	mcfs_adc_type adc_q;

	assign load_normal = ce_fall & ~info_pend_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			info_pend_q <= 1'b0;
		end else if (en_in) begin
			if (is_config && word_q[INFO_REQ_BIT]) begin
				info_pend_q <= 1'b1;
			end else if (ce_fall) begin
				info_pend_q <= 1'b0;
			end
		end
	end

	// Done flags survive information frames and leave with one normal frame
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			done1_q <= 1'b0;
			done2_q <= 1'b0;
		end else if (en_in) begin
			done1_q <= first_done_in | (done1_q & ~load_normal);
			done2_q <= second_done_in | (done2_q & ~load_normal);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			adc_q <= ADC_RESET;
		end else if (en_in && (first_done_in || second_done_in)) begin
			adc_q <= adc_in;
		end
	end

	// ------------------------------------------------------------
	// Transmit shifter
	// ------------------------------------------------------------
	// Driven from the system clock so the first bit is ready at
	// chip enable; costs up to three clocks of delay after each edge.
	logic [15:0] tx_q;
	logic [15:0] tx_word;

	assign tx_word = info_pend_q ? info_frame(st_s2_q, enc_filt)
		: normal_frame(adc_q, enc_filt, done1_q, done2_q);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tx_q     <= FRAME_RESET;
			miso_out <= 1'b0;
		end else if (en_in) begin
			if (ce_fall) begin
				tx_q     <= tx_word;
				miso_out <= tx_word[15];
			end else if (sclk_fall && !ce_n_s2_q) begin
				tx_q     <= {tx_q[14:0], 1'b0};
				miso_out <= tx_q[14];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			miso_oe_n_out <= 1'b1;
		end else if (en_in) begin
			miso_oe_n_out <= ce_n_s2_q;
		end
	end

	// ------------------------------------------------------------
	// Driver C side selection and analog test routing
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			low_side_outputs_en_out  <= 1'b0;
			high_side_outputs_en_out <= 1'b0;
		end else if (en_in) begin
			low_side_outputs_en_out  <= cfg_out.driver_c_mode_select;
			high_side_outputs_en_out <= ~cfg_out.driver_c_mode_select;
		end
	end

	// Debug aid only; pins carry the filtered phases while enabled
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			analog_pin_zero_out <= 1'b0;
			analog_pin_one_out  <= 1'b0;
		end else if (en_in) begin
			analog_pin_zero_out <= cfg_out.analog_test & enc_filt[0];
			analog_pin_one_out  <= cfg_out.analog_test & enc_filt[1];
		end
	end

endmodule : mcfs_frame_core

// ### verif/mcfs_frame_core_checker.sv
// Assertion checker bound to mcfs_frame_core, watching its ports only.
// Assumes the host keeps sclk_in low and ce_n_in high outside frames.

module mcfs_frame_core_checker
	import mcfs_pkg::*;
(
	input  wire logic                                            clk_in,
	input  wire logic                                            rst_in,
	input  wire logic                                            sclk_in,
	input  wire logic                                            ce_n_in,
	input  wire logic                                            miso_oe_n_out,
	input  wire mcfs_pkg::mcfs_cfg_type                          cfg_out,
	input  wire logic [mcfs_pkg::CAL_REGS-1:0][mcfs_pkg::CAL_W-1:0] cal_out,
	input  wire logic [mcfs_pkg::FRAME_BITS-1:0]                 normal_frame_out,
	input  wire logic                                            normal_valid_out,
	input  wire logic                                            low_side_outputs_en_out,
	input  wire logic                                            high_side_outputs_en_out,
	input  wire logic                                            analog_pin_zero_out,
	input  wire logic                                            analog_pin_one_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------
	// Frame age
	// ------------
	logic [1:0] sync_q;
	logic [3:0] edge_q;
	logic [3:0] age_q;
	logic       rise;

	assign rise = sync_q[0] & ~sync_q[1];

	// One flop is enough here; no metastability in simulation
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_q <= '0;
			edge_q <= '0;
		end else begin
			sync_q <= {sync_q[0], sclk_in};
			edge_q <= ce_n_in ? 4'h0 : edge_q + {3'h0, rise};
		end
	end

	// Cycles since the sixteenth edge of a frame, saturating
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			age_q <= 4'hf;
		else if (rise && !ce_n_in && edge_q == 4'hf)
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
	end

	// ------------
	// Properties
	// ------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	property p_cfg_framed;
		$changed(cfg_out) || $changed(cal_out) |-> age_q <= 4'h7;
	endproperty
	a_cfg_framed: assert property (p_cfg_framed)
		else $error("settings changed without a complete frame");
	property p_valid_framed;
		normal_valid_out |-> age_q <= 4'h7;
	endproperty
	a_valid_framed: assert property (p_valid_framed)
		else $error("normal frame taken without a complete frame");
	property p_valid_kind;
		normal_valid_out |-> !normal_frame_out[0] ##1 !normal_valid_out;
	endproperty
	a_valid_kind: assert property (p_valid_kind)
		else $error("normal frame pulse wrong");
	property p_drv_follow;
		$changed(cfg_out.driver_c_mode_select) |=> low_side_outputs_en_out == $past(cfg_out.driver_c_mode_select);
	endproperty
	a_drv_follow: assert property (p_drv_follow)
		else $error("low side enable does not follow mode");
	property p_drv_excl;
		!$past(rst_in) && !$past(rst_in, 2) |-> high_side_outputs_en_out != low_side_outputs_en_out;
	endproperty
	a_drv_excl: assert property (p_drv_excl)
		else $error("high and low side enables not exclusive");
	property p_pin_off;
		!cfg_out.analog_test && !$past(cfg_out.analog_test) |-> !analog_pin_zero_out && !analog_pin_one_out;
	endproperty
	a_pin_off: assert property (p_pin_off)
		else $error("analog pins driven outside test mode");
	property p_oe_on;
		$fell(ce_n_in) |-> ##[1:5] !miso_oe_n_out;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("output not enabled after select");
	property p_oe_off;
		ce_n_in [*6] |-> miso_oe_n_out;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output enabled while deselected");

	c_cfg: cover property ($changed(cfg_out));
	c_valid: cover property (normal_valid_out);
	c_analog: cover property (cfg_out.analog_test);

endmodule : mcfs_frame_core_checker

bind mcfs_frame_core mcfs_frame_core_checker i_chk (
	.clk_in, .rst_in, .sclk_in, .ce_n_in, .miso_oe_n_out, .cfg_out, .cal_out,
	.normal_frame_out, .normal_valid_out, .low_side_outputs_en_out,
	.high_side_outputs_en_out, .analog_pin_zero_out, .analog_pin_one_out
);

// ### verif/mcfs_host_model.sv
// Host side of the serial link: shifts frames out MSB first, samples replies.
// Assumes the bench starts one frame at a time through xfer.

module mcfs_host_model (
	output logic      sclk_out,
	output logic      ce_n_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// Deselect only after the bench raises reset, so link flops see a reset edge
	initial begin
		sclk_out = 1'b0;
		mosi_out = 1'b0;
		#2;
		ce_n_out = 1'b1;
	end

	// Fewer than 16 edges aborts the frame; lag slows the serial clock
	task automatic xfer(input logic [15:0] tx, input int edges, input int lag, output logic [15:0] rx);
		logic [15:0] f;
		f = tx;
		rx = '0;
		if (f[0])
			f[15:14] = 2'b10;
		#3;
		ce_n_out = 1'b0;
		#8;
		for (int i = 15; i > 15 - edges; i--) begin
			mosi_out = f[i];
			#(40 + lag);
			rx[i] = miso_in;
			sclk_out = 1'b1;
			#(40 + lag);
			sclk_out = 1'b0;
		end
		#40;
		ce_n_out = 1'b1;
		// Released line shows the inverse, never a stale bit
		mosi_out = ~mosi_out;
		#48;
	endtask : xfer

endmodule : mcfs_host_model

// ### verif/tb_mcfs_frame_core.sv
// Self-checking bench for mcfs_frame_core; the link is driven by the host model.
// Assumes the bound checker and the host model are compiled alongside.

module tb_mcfs_frame_core
	import mcfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic                           clk_in = 1'b0;
	logic                           rst_in = 1'b0;
	logic                           sclk, ce_n, mosi, miso, oe_n;
	mcfs_adc_type                   adc = ADC_RESET;
	logic                           done1 = 1'b0;
	logic                           done2 = 1'b0;
	mcfs_status_type                status = 7'h53;
	logic                           enc_a = 1'b1;
	logic                           enc_b = 1'b0;
	mcfs_cfg_type                   cfg;
	logic [CAL_REGS-1:0][CAL_W-1:0] cal;
	logic [15:0]                    nf, rx;
	logic                           nv, low_en, high_en, pin0, pin1;
	int                             error_cnt = 0;
	int                             compares = 0;

	always #4 clk_in = ~clk_in;

	mcfs_host_model i_host (.sclk_out(sclk), .ce_n_out(ce_n), .mosi_out(mosi), .miso_in(miso));

	mcfs_frame_core i_dut (
		.clk_in(clk_in), .rst_in(rst_in), .en_in(1'b1), .sclk_in(sclk), .ce_n_in(ce_n),
		.mosi_in(mosi), .miso_out(miso), .miso_oe_n_out(oe_n), .adc_in(adc),
		.first_done_in(done1), .second_done_in(done2), .status_in(status),
		.encoder_phase_a_in(enc_a), .encoder_phase_b_in(enc_b), .cfg_out(cfg), .cal_out(cal),
		.normal_frame_out(nf), .normal_valid_out(nv), .low_side_outputs_en_out(low_en),
		.high_side_outputs_en_out(high_en), .analog_pin_zero_out(pin0), .analog_pin_one_out(pin1)
	);

	// ------------
	// Tasks
	// ------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic send(input logic [15:0] tx);
		i_host.xfer(tx, 16, 0, rx);
	endtask : send

	task automatic pulse(input logic second, input mcfs_adc_type v);
		@(negedge clk_in);
		adc = v;
		done1 = !second;
		done2 = second;
		@(negedge clk_in);
		done1 = 1'b0;
		done2 = 1'b0;
	endtask : pulse

	task automatic end_of_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// ------------
	// Tests
	// ------------
	initial begin
		int         pos[5];
		logic [4:0] cal_exp[4];
		pos = '{2, 3, 4, 5, 8};
		// Reset rises after time zero so every async reset sees an edge
		#1;
		rst_in = 1'b1;
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
		chk("cfg", 16'h0000, 16'(cfg));
		chk("drv", 16'h0001, 16'({low_en, high_en}));
		for (int j = 0; j < 5; j++) begin
			send(16'h0001 | (16'h0001 << pos[j]));
			chk("cfg", 16'h0001 << j, 16'(cfg));
		end
		send(16'h013d);
		chk("cfg", 16'h001f, 16'(cfg));
		chk("drv", 16'h0002, 16'({low_en, high_en}));
		chk("pins", 16'h0002, 16'({pin0, pin1}));
		i_host.xfer(16'h0001, 8, 0, rx);
		chk("cfg", 16'h001f, 16'(cfg));
		i_host.xfer(16'h0001, 16, 40, rx);
		chk("cfg", 16'h0000, 16'(cfg));
		chk("drv", 16'h0001, 16'({low_en, high_en}));
		chk("pins", 16'h0000, 16'({pin0, pin1}));
		send(16'h1234);
		chk("normal", 16'h1234, nf);
		chk("cfg", 16'h0000, 16'(cfg));
		for (int s = 0; s < 4; s++) begin
			chk("cal", 16'h0000, 16'(cal[s]));
			cal_exp[s] = 5'h13 + 5'(7 * s);
			send({2'b10, cal_exp[s], 1'b0, 2'(s), 6'h01});
		end
		for (int s = 0; s < 4; s++)
			chk("cal", 16'(cal_exp[s]), 16'(cal[s]));
		pulse(1'b0, {8'ha5, 3'h5});
		send(16'h0000);
		chk("frame", 16'ha555, rx);
		send(16'h0000);
		chk("frame", 16'ha554, rx);
		pulse(1'b1, {8'h3c, 3'h2});
		send(16'h0000);
		chk("frame", 16'h3c26, rx);
		send(16'h0003);
		pulse(1'b0, {8'h81, 3'h0});
		send(16'h0000);
		chk("frame", 16'h1ac7, rx);
		send(16'h0000);
		chk("frame", 16'h8105, rx);
		// Three edges pass the short filter but not the long one
		send(16'h0021);
		@(negedge clk_in);
		enc_b = 1'b1;
		i_host.xfer(16'h0000, 3, 0, rx);
		send(16'h0000);
		chk("enc", 16'h0001, 16'(rx[3:2]));
		send(16'h0001);
		chk("enc", 16'h0003, 16'(rx[3:2]));
		@(negedge clk_in);
		enc_b = 1'b0;
		i_host.xfer(16'h0000, 3, 0, rx);
		send(16'h0000);
		chk("enc", 16'h0001, 16'(rx[3:2]));
		end_of_test();
	end

	// Tests take about 33 us; a hang stops well after that
	initial begin
		#100us;
		error_cnt++;
		end_of_test();
	end

endmodule : tb_mcfs_frame_core
